/* asif_pkg.sv */
package asif_pkg;

   // framing selections; the all-zero code is the power-up default
   localparam logic [1:0] FMT_I2S = 2'h0;
   localparam logic [1:0] FMT_LEFT = 2'h1;
   localparam logic [1:0] FMT_RIGHT = 2'h2;

   // word length selections
   localparam logic [1:0] LEN_16 = 2'h0;
   localparam logic [1:0] LEN_18 = 2'h1;
   localparam logic [1:0] LEN_20 = 2'h2;
   localparam logic [1:0] LEN_24 = 2'h3;

   // word lengths in bits
   localparam logic [5:0] BITS_16 = 6'h10;
   localparam logic [5:0] BITS_18 = 6'h12;
   localparam logic [5:0] BITS_20 = 6'h14;
   localparam logic [5:0] BITS_24 = 6'h18;

   // data path width and slot geometry
   localparam int WORD_W = 24;
   localparam logic [5:0] SLOT_BITS = 6'h20;
   localparam logic [5:0] POS_MAX = 6'h3F;
   localparam logic [5:0] I2S_DELAY = 6'h01;
   localparam logic [5:0] LEFT_DELAY = 6'h00;

   // input synchroniser depth
   localparam int SYNC_DEPTH = 2;

   // capture state
   typedef enum logic [0:0] {
      ST_HUNT = 1'b0,
      ST_RUN = 1'b1
   } asif_state_t;

endpackage

/* asif_bit_if.sv */
`timescale 1ns/100ps
// one sampled serial bit per rising bit clock edge
interface asif_bit_if;
   logic bit_stb;
   logic bit_data;
   logic bit_lr;
   modport src (output bit_stb, output bit_data, output bit_lr);
   modport snk (input bit_stb, input bit_data, input bit_lr);
endinterface

/* asif_bit_sampler.sv */
`timescale 1ns/100ps
module asif_bit_sampler (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic bclk_in,
   input wire logic lrclk_in,
   input wire logic sdata_in,
   asif_bit_if.src bits
);

   ////////////////////////////////////////////////////////////////////////
   // two-flop synchronisers; stage 0 feeds only stage 1
   logic [2:0] meta;
   logic [2:0] sync;
   logic bclk_last;
   logic [2:0] next_meta;
   logic [2:0] next_sync;
   logic next_bclk_last;
   logic next_stb;
   logic next_data;
   logic next_lr;

   // next values: shift pins in, find rising bit clock edge
   always_comb begin
      next_meta = {bclk_in, lrclk_in, sdata_in};
      next_sync = meta;
      next_bclk_last = sync[2];
      next_stb = sync[2] & ~bclk_last;
      next_data = sync[0];
      next_lr = sync[1];
   end

   // registers
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         meta <= 3'h0;
         sync <= 3'h0;
         bclk_last <= 1'b0;
         bits.bit_stb <= 1'b0;
         bits.bit_data <= 1'b0;
         bits.bit_lr <= 1'b0;
      end else begin
         meta <= next_meta;
         sync <= next_sync;
         bclk_last <= next_bclk_last;
         bits.bit_stb <= next_stb;
         bits.bit_data <= next_data;
         bits.bit_lr <= next_lr;
      end
   end

endmodule // asif_bit_sampler

/* asif_formatter.sv */
`timescale 1ns/100ps
// Behaviour
// - accepts left-justified, I2S or right-justified framing, 16/18/20/24-bit words
// - framing code zero selects I2S, so I2S is the default
// - data bits are captured on the rising bit clock edge
// - left/right-justified: channel select high is left, low is right
// - I2S: channel select low is left, high is right
// - I2S: MSB comes one bit period after each channel select change
// - left-justified: MSB in first bit period after the change
// - right-justified: MSB starts 32 minus word length periods after change
module asif_formatter (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic bclk_in,
   input wire logic lrclk_in,
   input wire logic sdata_in,
   input wire logic [1:0] format_in,
   input wire logic [1:0] word_len_in,
   output logic [23:0] word_out,
   output logic word_left_out,
   output logic word_valid_out
);

   ////////////////////////////////////////////////////////////////////////
   // pin sampling
   asif_bit_if bits_if ();

   asif_bit_sampler u_sampler (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .bclk_in(bclk_in),
      .lrclk_in(lrclk_in),
      .sdata_in(sdata_in),
      .bits(bits_if.src)
   );

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // word length code to bit count
   function automatic logic [5:0] len_bits(input logic [1:0] code);
      logic [5:0] r;
      r = asif_pkg::BITS_24;
      case (code)
         asif_pkg::LEN_16: r = asif_pkg::BITS_16;
         asif_pkg::LEN_18: r = asif_pkg::BITS_18;
         asif_pkg::LEN_20: r = asif_pkg::BITS_20;
         default: r = asif_pkg::BITS_24;
      endcase
      return r;
   endfunction

   // bit periods from channel select change to MSB
   function automatic logic [5:0] msb_delay(input logic [1:0] fmt, input logic [5:0] len);
      logic [5:0] r;
      r = asif_pkg::I2S_DELAY;
      case (fmt)
         asif_pkg::FMT_LEFT: r = asif_pkg::LEFT_DELAY;
         asif_pkg::FMT_RIGHT: r = asif_pkg::SLOT_BITS - len;
         default: r = asif_pkg::I2S_DELAY;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // capture state
   asif_pkg::asif_state_t state;
   asif_pkg::asif_state_t next_state;
   logic lr_last;
   logic next_lr_last;
   logic [5:0] pos;
   logic [5:0] next_pos;
   logic [1:0] cfg_fmt;
   logic [1:0] next_cfg_fmt;
   logic [5:0] cfg_len;
   logic [5:0] next_cfg_len;
   logic chan_left;
   logic next_chan_left;
   logic [4:0] cnt;
   logic [4:0] next_cnt;
   logic [23:0] sreg;
   logic [23:0] next_sreg;
   logic [23:0] next_word;
   logic next_word_left;
   logic next_word_valid;
   // slot decode of the bit now on offer
   logic lr_change;
   logic [5:0] use_len;
   logic [1:0] use_fmt;
   logic [5:0] use_pos;
   logic use_left;
   logic [5:0] start;
   logic [5:0] stop;
   logic in_slot;
   logic last_bit;

   ////////////////////////////////////////////////////////////////////////
   // slot decode: a channel select change opens a slot and takes the config

   // config and tag for this bit; mid-slot config changes wait for the next slot
   always_comb begin
      lr_change = bits_if.bit_stb & (bits_if.bit_lr != lr_last);
      use_len = cfg_len;
      use_fmt = cfg_fmt;
      use_pos = pos;
      use_left = chan_left;
      if (lr_change) begin
         use_len = len_bits(word_len_in);
         use_fmt = format_in;
         use_pos = 6'h00;
         if (format_in == asif_pkg::FMT_LEFT || format_in == asif_pkg::FMT_RIGHT) begin
            use_left = bits_if.bit_lr;
         end else begin
            use_left = ~bits_if.bit_lr;
         end
      end
      start = msb_delay(use_fmt, use_len);
      stop = start + use_len;
      // only bits inside the word slot count; nothing before the first change
      in_slot = (state == asif_pkg::ST_RUN) | lr_change;
      in_slot = in_slot & (use_pos >= start) & (use_pos < stop);
      last_bit = in_slot && use_pos == stop - 6'h01;
   end

   ////////////////////////////////////////////////////////////////////////
   // slot tracking

   // next values: position saturates so a long frame cannot wrap into a slot
   always_comb begin
      next_state = state;
      next_lr_last = lr_last;
      next_pos = pos;
      next_cfg_fmt = cfg_fmt;
      next_cfg_len = cfg_len;
      next_chan_left = chan_left;
      if (bits_if.bit_stb) begin
         next_lr_last = bits_if.bit_lr;
         if (use_pos != asif_pkg::POS_MAX) begin
            next_pos = use_pos + 6'h01;
         end else begin
            next_pos = use_pos;
         end
      end
      if (lr_change) begin
         next_state = asif_pkg::ST_RUN;
         next_cfg_fmt = use_fmt;
         next_cfg_len = use_len;
         next_chan_left = use_left;
      end
   end

   // registers; hunts until the first channel select change after reset
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         state <= asif_pkg::ST_HUNT;
         lr_last <= 1'b0;
         pos <= asif_pkg::POS_MAX;
         cfg_fmt <= asif_pkg::FMT_I2S;
         cfg_len <= asif_pkg::BITS_16;
         chan_left <= 1'b0;
      end else begin
         state <= next_state;
         lr_last <= next_lr_last;
         pos <= next_pos;
         cfg_fmt <= next_cfg_fmt;
         cfg_len <= next_cfg_len;
         chan_left <= next_chan_left;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shift register: bits land MSB first from bit 23 down

   // next values; a new slot clears the word so short words come out zero-padded
   always_comb begin
      next_cnt = cnt;
      next_sreg = sreg;
      if (lr_change) begin
         next_cnt = 5'h00;
         next_sreg = 24'h000000;
      end
      if (bits_if.bit_stb && in_slot) begin
         next_sreg[5'(asif_pkg::WORD_W - 1) - next_cnt] = bits_if.bit_data;
         next_cnt = next_cnt + 5'h01;
      end
   end

   // registers
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         cnt <= 5'h00;
         sreg <= 24'h000000;
      end else begin
         cnt <= next_cnt;
         sreg <= next_sreg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // delivery: a finished word and its channel tag go out in one transfer

   // next values: load on the last slot bit, valid pulses for one cycle
   always_comb begin
      next_word = word_out;
      next_word_left = word_left_out;
      next_word_valid = 1'b0;
      if (bits_if.bit_stb && last_bit) begin
         next_word = next_sreg;
         next_word_left = use_left;
         next_word_valid = 1'b1;
      end
   end

   // output registers; word and tag stand until the next word
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         word_out <= 24'h000000;
         word_left_out <= 1'b0;
         word_valid_out <= 1'b0;
      end else begin
         word_out <= next_word;
         word_left_out <= next_word_left;
         word_valid_out <= next_word_valid;
      end
   end

endmodule // asif_formatter

/* asif_formatter_chk.sv */
`timescale 1ns/100ps
// pin-level watch on word delivery, channel tag and slot trimming
module asif_formatter_chk (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic bclk_in,
   input wire logic lrclk_in,
   input wire logic sdata_in,
   input wire logic [1:0] format_in,
   input wire logic [1:0] word_len_in,
   input wire logic [23:0] word_out,
   input wire logic word_left_out,
   input wire logic word_valid_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   // bit clock rise first seen four edges back
   sequence s_rise_seen;
      $past(bclk_in, 4) && !$past(bclk_in, 5);
   endsequence
   AST_PULSE: assert property (word_valid_out |=> !word_valid_out)
      else $error("valid longer than one cycle");
   AST_RST: assert property (disable iff (1'b0) reset_in |=> !word_valid_out && word_out == 24'h0)
      else $error("outputs not cleared by reset");
   AST_HOLD: assert property (!word_valid_out |-> $stable(word_out) && $stable(word_left_out))
      else $error("word changed without valid");
   AST_ON_RISE: assert property (word_valid_out |-> s_rise_seen)
      else $error("word not tied to a bit clock rise");
   AST_TRIM16: assert property (word_valid_out && word_len_in == 2'h0 |-> word_out[7:0] == 8'h00)
      else $error("stray bits in 16-bit word");
   AST_TRIM20: assert property (word_valid_out && word_len_in == 2'h2 |-> word_out[3:0] == 4'h0)
      else $error("stray bits in 20-bit word");
   AST_LEFT_LJ: assert property (word_valid_out && format_in == 2'h1 |-> word_left_out == lrclk_in)
      else $error("left tag wrong in left-justified");
   AST_LEFT_I2S: assert property (word_valid_out && (format_in == 2'h0 || format_in == 2'h3)
      |-> word_left_out != lrclk_in)
      else $error("left tag wrong in i2s");
endmodule // asif_formatter_chk

/* asif_src_model.sv */
`timescale 1ns/100ps
// audio source: bit clock stands low between frames
module asif_src_model (
   input wire logic core_clk_in,
   output logic bclk_out,
   output logic lrclk_out,
   output logic sdata_out
);
   initial begin
      bclk_out = 1'b0;
      lrclk_out = 1'b0;
      sdata_out = 1'b0;
   end
   // change while low, hold through the rise, 320 ns per bit
   task automatic bit_cycle(input logic lr, input logic d);
      lrclk_out = lr;
      sdata_out = d;
      repeat (4) @(posedge core_clk_in);
      #1 bclk_out = 1'b1;
      repeat (4) @(posedge core_clk_in);
      #1 bclk_out = 1'b0;
   endtask
   // one left and one right slot of 32 bits each
   task automatic send_frame(input int fmt, input int len, input logic [23:0] wl, wr);
      int st;
      logic lvl;
      logic [23:0] w;
      st = (fmt == 1) ? 0 : (fmt == 2) ? 32 - len : 1;
      lvl = (fmt == 1 || fmt == 2);
      bit_cycle(!lvl, ~sdata_out);
      for (int c = 0; c < 2; c++) begin
         w = c ? wr : wl;
         for (int p = 0; p < 32; p++)
            bit_cycle(lvl ^ c[0], (p >= st && p < st + len) ? w[len - 1 - p + st] : 1'($urandom));
      end
      sdata_out = ~sdata_out; // released line shows no stale value
   endtask
endmodule // asif_src_model

/* asif_formatter_tb.sv */
`timescale 1ns/100ps
// every framing and word length, two frames back to back each
module asif_formatter_tb;
   logic core_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic bclk;
   logic lrclk;
   logic sdata;
   logic [1:0] format_in = 2'h0;
   logic [1:0] word_len_in = 2'h0;
   logic [23:0] word_out;
   logic word_left_out;
   logic word_valid_out;
   logic [24:0] e;
   logic [24:0] exp_q[$];
   int num_errors = 0;
   int samples_checked = 0;
   always #20 core_clk_in = ~core_clk_in;
   asif_src_model i_asif_src_model (.core_clk_in(core_clk_in), .bclk_out(bclk),
      .lrclk_out(lrclk), .sdata_out(sdata));
   asif_formatter i_asif_formatter (.core_clk_in, .reset_in, .bclk_in(bclk), .lrclk_in(lrclk),
      .sdata_in(sdata), .format_in, .word_len_in, .word_out, .word_left_out, .word_valid_out);
   task automatic check(input string what, input logic [23:0] exp, got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done();
      $display("compared %0d mismatched %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // each delivered word against the oldest expected one
   always @(negedge core_clk_in) begin
      if (!reset_in && word_valid_out === 1'b1) begin
         if (exp_q.size() == 0) check("extra word", 24'h0, 24'h1);
         else begin
            e = exp_q.pop_front();
            check("word", e[23:0], word_out);
            check("channel", {23'h0, e[24]}, {23'h0, word_left_out});
         end
      end
   end
   initial begin
      repeat (30000) @(posedge core_clk_in);
      num_errors++;
      test_done();
   end
   initial begin
      int lens[4] = '{16, 18, 20, 24};
      logic [23:0] wl;
      logic [23:0] wr;
      void'($urandom(32'h8BC0E7DD));
      repeat (6) @(posedge core_clk_in);
      #1 reset_in = 1'b0;
      @(posedge core_clk_in);
      #1;
      check("reset word", 24'h0, word_out);
      check("reset flags", 24'h0, {22'h0, word_valid_out, word_left_out});
      for (int f = 0; f < 4; f++) begin
         for (int l = 0; l < 4; l++) begin
            format_in = 2'(f);
            word_len_in = 2'(l);
            repeat (2) begin
               wl = 24'($urandom) & ((24'h1 << lens[l]) - 24'h1);
               wr = 24'($urandom) & ((24'h1 << lens[l]) - 24'h1);
               exp_q.push_back({1'b1, wl << (24 - lens[l])});
               exp_q.push_back({1'b0, wr << (24 - lens[l])});
               i_asif_src_model.send_frame(f, lens[l], wl, wr);
            end
            repeat (8) @(posedge core_clk_in);
            #1 $display("test format %0d length %0d done", f, lens[l]);
         end
      end
      check("missing words", 24'h0, 24'(exp_q.size()));
      test_done();
   end
endmodule // asif_formatter_tb
bind asif_formatter asif_formatter_chk i_asif_formatter_chk (.core_clk_in, .reset_in, .bclk_in,
   .lrclk_in, .sdata_in, .format_in, .word_len_in, .word_out, .word_left_out, .word_valid_out);
